// ### core/psp_controller.sv
// system controller end: sequences reset, decodes status, apb registers
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module psp_controller (
  input  wire logic        I_CLK,      // 40 mhz clock
  input  wire logic        I_RST,      // synchronous reset, active high
  psp_if.ctl               lnk,        // link to power stage
  input  wire logic        i_psel,     // apb select
  input  wire logic        i_penable,  // apb enable
  input  wire logic        i_pwrite,   // apb direction
  input  wire logic [7:0]  i_paddr,    // apb byte address
  input  wire logic [31:0] i_pwdata,   // apb write data
  output logic             o_pready,   // apb ready
  output logic [31:0]      o_prdata,   // apb read data
  output logic             o_pslverr,  // apb error, unmapped address
  output logic             o_pwm_en,   // run modulator
  output logic             o_irq       // level interrupt
);
  // ******************************************************
  // registers
  // ******************************************************
  logic [1:0]  ctrl_r, ctrl_nxt;         // bit0 run request, bit1 modulator enable
  logic [3:0]  ist_r, ist_nxt;           // sticky events
  logic [3:0]  imask_r, imask_nxt;       // event mask
  logic [1:0]  stat_d_r;                 // previous decoded status
  logic [psp_pkg::CNT_W-1:0] cnt_r, cnt_nxt;  // wait counter
  psp_pkg::psp_ctl_state_t st_r, st_nxt; // sequencing state
  logic [1:0]  stat;                     // {temp_warning_n, fault_status_n}
  logic [3:0]  evt;                      // events this cycle
  logic        wr, rd, hit;              // apb access qualifiers

  assign stat = {lnk.temp_warning_n, lnk.fault_status_n};
  assign wr   = i_psel & i_penable & i_pwrite;
  assign rd   = i_psel & i_penable & ~i_pwrite;
  assign hit  = (i_paddr == psp_pkg::REG_CTRL) || (i_paddr == psp_pkg::REG_STATUS)
             || (i_paddr == psp_pkg::REG_IRQ_STAT) || (i_paddr == psp_pkg::REG_IRQ_MASK);

  // event detection from falling status pins and reset release
  always_comb begin
    evt = 4'h0;
    evt[psp_pkg::IRQ_FAULT] = stat_d_r[0] & ~stat[0];
    evt[psp_pkg::IRQ_WARN]  = stat_d_r[1] & ~stat[1];
    evt[psp_pkg::IRQ_OTE]   = (stat == psp_pkg::STAT_OT_ERR) && (stat_d_r != psp_pkg::STAT_OT_ERR);
    evt[psp_pkg::IRQ_RUN]   = (st_r == psp_pkg::PSC_PWM_WAIT) && (st_nxt == psp_pkg::PSC_RUN);
  end

  // ******************************************************
  // sequencer
  // ******************************************************
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = (cnt_r == '0) ? cnt_r : cnt_r - 1'b1;
    case (st_r)
      psp_pkg::PSC_OFF: begin                 // reset low, modulator off
        // start only with the modulator enabled too, so pwm runs before reset rises
        if (&ctrl_r) begin
          st_nxt  = psp_pkg::PSC_HOLD;
          cnt_nxt = psp_pkg::CNT_W'(psp_pkg::RST_LOW_CYC);
        end
      end
      psp_pkg::PSC_HOLD: begin                // minimum reset low time
        if (cnt_r == '0) begin
          st_nxt  = psp_pkg::PSC_PWM_WAIT;
          cnt_nxt = psp_pkg::CNT_W'(psp_pkg::PWM_STABLE_CYC);
        end
      end
      psp_pkg::PSC_PWM_WAIT: begin            // pwm running, let it settle
        if (ctrl_r != 2'h3) st_nxt = psp_pkg::PSC_STOP;
        else if (cnt_r == '0) st_nxt = psp_pkg::PSC_RUN;
      end
      psp_pkg::PSC_RUN: begin
        if (stat != psp_pkg::STAT_NORMAL && stat != psp_pkg::STAT_OT_WARN)
          st_nxt = psp_pkg::PSC_FAULT;
        else if (ctrl_r != 2'h3) st_nxt = psp_pkg::PSC_STOP;
      end
      psp_pkg::PSC_FAULT: begin               // reset held low until software retries
        if (!ctrl_r[0]) st_nxt = psp_pkg::PSC_OFF;
      end
      psp_pkg::PSC_STOP: begin                // reset low for a cycle before pwm stops
        st_nxt = psp_pkg::PSC_OFF;
      end
      default: st_nxt = psp_pkg::PSC_OFF;
    endcase
  end

  // ******************************************************
  // apb register file
  // ******************************************************
  always_comb begin
    ctrl_nxt  = ctrl_r;
    imask_nxt = imask_r;
    ist_nxt   = ist_r;
    if (wr && i_paddr == psp_pkg::REG_CTRL) ctrl_nxt = i_pwdata[1:0];
    if (wr && i_paddr == psp_pkg::REG_IRQ_MASK) imask_nxt = i_pwdata[3:0];
    if (wr && i_paddr == psp_pkg::REG_IRQ_STAT) ist_nxt = ist_r & ~i_pwdata[3:0];
    ist_nxt = ist_nxt | evt;                  // set wins over clear
    // a fault drops the run request so retry is a deliberate toggle
    if (st_r == psp_pkg::PSC_RUN && st_nxt == psp_pkg::PSC_FAULT) ctrl_nxt[0] = 1'b0;
  end

  // register all controller state
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      st_r     <= psp_pkg::PSC_OFF;
      cnt_r    <= '0;
      ctrl_r   <= psp_pkg::CTRL_RST_VAL[1:0];
      imask_r  <= psp_pkg::MASK_RST_VAL;
      ist_r    <= 4'h0;
      stat_d_r <= psp_pkg::STAT_NORMAL;
      o_prdata <= 32'h0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      ctrl_r   <= ctrl_nxt;
      imask_r  <= imask_nxt;
      ist_r    <= ist_nxt;
      stat_d_r <= stat;
      if (i_psel && !i_penable && !i_pwrite) begin   // capture in setup cycle
        case (i_paddr)
          psp_pkg::REG_CTRL:     o_prdata <= {30'h0, ctrl_r};
          psp_pkg::REG_STATUS:   o_prdata <= {27'h0, st_r, stat};
          psp_pkg::REG_IRQ_STAT: o_prdata <= {28'h0, ist_r};
          psp_pkg::REG_IRQ_MASK: o_prdata <= {28'h0, imask_r};
          default:               o_prdata <= 32'h0;
        endcase
      end
    end
  end

  // straps tied to the only supported settings
  assign lnk.protect_mode_sel_hi = 1'b0;
  assign lnk.protect_mode_sel_lo = 1'b1;
  assign lnk.output_mode_sel     = 1'b0;
  assign lnk.reset_n    = (st_r == psp_pkg::PSC_RUN);
  assign lnk.pwm_active = o_pwm_en;
  // once reset is high the modulator keeps running until reset has been low a cycle
  assign o_pwm_en  = (st_r == psp_pkg::PSC_RUN) || (st_r == psp_pkg::PSC_STOP)
                   || (st_r == psp_pkg::PSC_FAULT)
                   || (ctrl_r[1] && st_r == psp_pkg::PSC_HOLD)
                   || (ctrl_r[1] && st_r == psp_pkg::PSC_PWM_WAIT);
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~hit;
  assign o_irq     = |(ist_r & imask_r);
  logic unused_rd;
  assign unused_rd = rd;
endmodule : psp_controller
`default_nettype wire

// ### core/psp_pkg.sv
// shared constants and types for the power stage protection link
package psp_pkg;
  // ******************************************************
  // strap encodings
  // ******************************************************
  localparam logic [1:0] MODE_LATCHED   = 2'h1;   // hi=0, lo=1 selects latched shutdown
  localparam logic       OUT_MODE_BTL   = 1'h0;   // bridge tied load output stage
  // ******************************************************
  // status decode of {temp_warning_n, fault_status_n}
  // ******************************************************
  localparam logic [1:0] STAT_OT_ERR    = 2'h0;   // overtemperature error
  localparam logic [1:0] STAT_OT_WARN   = 2'h1;   // overtemperature warning
  localparam logic [1:0] STAT_OC_UV_ERR = 2'h2;   // overcurrent or undervoltage error
  localparam logic [1:0] STAT_NORMAL    = 2'h3;   // normal operation
  // ******************************************************
  // controller register map (apb, byte addresses)
  // ******************************************************
  localparam logic [7:0] REG_CTRL       = 8'h00;  // bit0 run request, bit1 modulator enable
  localparam logic [7:0] REG_STATUS     = 8'h04;  // live pin status, state
  localparam logic [7:0] REG_IRQ_STAT   = 8'h08;  // sticky events, write one to clear
  localparam logic [7:0] REG_IRQ_MASK   = 8'h0c;  // interrupt enables
  localparam logic [31:0] CTRL_RST_VAL  = 32'h0;  // reset value of control
  localparam logic [3:0]  MASK_RST_VAL  = 4'h0;   // reset value of mask
  // irq bit positions
  localparam int IRQ_FAULT = 0;                   // fault_status_n fell
  localparam int IRQ_WARN  = 1;                   // temp_warning_n fell
  localparam int IRQ_OTE   = 2;                   // overtemperature error decoded
  localparam int IRQ_RUN   = 3;                   // reset released (stage running)
  // ******************************************************
  // timing
  // ******************************************************
  localparam int CLK_HZ         = 40_000_000;     // system clock rate
  localparam int RST_LOW_NS     = 1000;           // least time reset held low
  localparam int RST_LOW_CYC    = (RST_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PWM_STABLE_NS  = 10000;          // pwm running time before reset rises
  localparam int PWM_STABLE_CYC = (PWM_STABLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CNT_W          = 16;             // width of the wait counter
  // controller sequencing states
  typedef enum logic [2:0] {
    PSC_OFF, PSC_HOLD, PSC_PWM_WAIT, PSC_RUN, PSC_FAULT, PSC_STOP
  } psp_ctl_state_t;
endpackage : psp_pkg

// ### core/psp_if.sv
// link between power stage protection logic and its controller
`timescale 1ns/10ps
`default_nettype none
interface psp_if;
  logic       reset_n;              // controller driven reset, active low
  logic       protect_mode_sel_hi;  // strap, controller side
  logic       protect_mode_sel_lo;  // strap, controller side
  logic       output_mode_sel;      // strap, controller side
  logic       pwm_active;           // controller pwm streams switching
  logic       fault_status_n_o;     // open drain output value (always 0)
  logic       fault_status_n_oe;    // device pulls fault_status_n low
  logic       temp_warning_n_o;     // open drain output value (always 0)
  logic       temp_warning_n_oe;    // device pulls temp_warning_n low
  wire        fault_status_n;       // resolved wire with pullup
  wire        temp_warning_n;       // resolved wire with pullup
  // pullups resolve the open drain pins
  assign fault_status_n = fault_status_n_oe ? fault_status_n_o : 1'b1;
  assign temp_warning_n = temp_warning_n_oe ? temp_warning_n_o : 1'b1;
  modport dev (
    input  reset_n, protect_mode_sel_hi, protect_mode_sel_lo, output_mode_sel, pwm_active,
    output fault_status_n_o, fault_status_n_oe, temp_warning_n_o, temp_warning_n_oe
  );
  modport ctl (
    output reset_n, protect_mode_sel_hi, protect_mode_sel_lo, output_mode_sel, pwm_active,
    input  fault_status_n, temp_warning_n
  );
endinterface : psp_if
`default_nettype wire

// ### core/psp_device.sv
// protection, error latch and status logic of the power stage
//
// Contract
// - fault_status_n low while running with error
// - reset low: outputs hi-z, fault_status_n high
// - temp_warning_n low above warning threshold
// - controller decodes warning/fault pair into state
// - any error sets whole stage hi-z
// - controller toggles reset only after errors clear (here on software retry, without checking the pins)
// - persistent error: controller keeps reset low
// - high and low side overcurrent per half-bridge
// - warning above 115C, shutdown above 150C
// - undervoltage on gate supply shuts stage down
// - reset asserted stops all switching
// - latch clears on reset fall, resume on rise
// - latched mode holds hi-z until reset toggled
// - protection straps must select latched mode
// - output strap must select bridge tied load
// - supply up with reset low: clear, release
// - pwm switching before controller raises reset
// - reset low before pwm stops at power-down
`timescale 1ns/10ps
`default_nettype none
module psp_device (
  input  wire logic       I_CLK,            // 40 mhz clock
  input  wire logic       I_RST,            // synchronous reset, active high
  psp_if.dev              lnk,              // link to controller
  input  wire logic [1:0] i_oc_hi,          // high side overcurrent per half-bridge
  input  wire logic [1:0] i_oc_lo,          // low side overcurrent per half-bridge
  input  wire logic       i_temp_warn,      // junction above 115C comparator
  input  wire logic       i_temp_shut,      // junction above 150C comparator
  input  wire logic       i_gate_supply_ok, // gate_drive_supply adequate
  input  wire logic       i_pwm_a,          // pwm in, half-bridge a
  input  wire logic       i_pwm_b,          // pwm in, half-bridge b
  output logic            o_out_a_hi,       // high side gate a
  output logic            o_out_a_lo,       // low side gate a
  output logic            o_out_b_hi,       // high side gate b
  output logic            o_out_b_lo,       // low side gate b
  output logic            o_hiz,            // output stage in high impedance
  output logic            o_err_latched,    // sticky error latch
  output logic            o_ot_latched      // latched error is overtemperature
);
  // ******************************************************
  // state
  // ******************************************************
  logic err_r, err_nxt;         // shared error latch
  logic ot_r, ot_nxt;           // error cause was overtemperature
  logic rst_n_d_r;              // previous reset level for edge detect
  logic run_r, run_nxt;         // stage switching allowed
  logic mode_ok;                // straps select a supported mode
  logic oc_any;                 // any overcurrent detection
  logic err_evt;                // any error event this cycle
  logic rst_fall, rst_rise;     // reset edges

  // ******************************************************
  // detection
  // ******************************************************
  // each switch is a separate event source; reduction merges them into one flag
  assign oc_any   = |{i_oc_hi, i_oc_lo};
  assign err_evt  = oc_any | i_temp_shut | ~i_gate_supply_ok;
  assign rst_fall = rst_n_d_r & ~lnk.reset_n;
  assign rst_rise = ~rst_n_d_r & lnk.reset_n;
  // reserved strap settings never let the stage run: safest reading
  assign mode_ok  = ({lnk.protect_mode_sel_hi, lnk.protect_mode_sel_lo} == psp_pkg::MODE_LATCHED)
                    && (lnk.output_mode_sel == psp_pkg::OUT_MODE_BTL);

  // next state of latch and run flag
  always_comb begin
    err_nxt = err_r;
    ot_nxt  = ot_r;
    run_nxt = run_r;
    if (rst_fall) begin
      err_nxt = 1'b0;
      ot_nxt  = 1'b0;
    end
    if (!lnk.reset_n && i_gate_supply_ok) begin
      err_nxt = 1'b0;
      ot_nxt  = 1'b0;
    end
    // a detection in the clearing cycle still wins, except undervoltage
    // while reset is low, which is the normal power-up case
    if (err_evt && (lnk.reset_n || oc_any || i_temp_shut)) begin
      err_nxt = 1'b1;
      ot_nxt  = ot_r | i_temp_shut;
    end
    if (!lnk.reset_n || err_evt) begin
      run_nxt = 1'b0;
    end else if (rst_rise && !err_r && mode_ok) begin
      run_nxt = 1'b1;
    end
    if (err_r) begin
      run_nxt = 1'b0;
    end
  end

  // register latch, run flag and reset history
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      err_r     <= 1'b0;
      ot_r      <= 1'b0;
      run_r     <= 1'b0;
      rst_n_d_r <= 1'b0;
    end else begin
      err_r     <= err_nxt;
      ot_r      <= ot_nxt;
      run_r     <= run_nxt;
      rst_n_d_r <= lnk.reset_n;
    end
  end

  // ******************************************************
  // output stage and status pins
  // ******************************************************
  // gates registered; hi-z means both switches off
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      o_out_a_hi <= 1'b0;
      o_out_a_lo <= 1'b0;
      o_out_b_hi <= 1'b0;
      o_out_b_lo <= 1'b0;
      o_hiz      <= 1'b1;
      lnk.fault_status_n_oe <= 1'b0;
      lnk.temp_warning_n_oe <= 1'b0;
    end else begin
      o_out_a_hi <= run_nxt & i_pwm_a;
      o_out_a_lo <= run_nxt & ~i_pwm_a;
      o_out_b_hi <= run_nxt & i_pwm_b;
      o_out_b_lo <= run_nxt & ~i_pwm_b;
      o_hiz      <= ~run_nxt;
      // pulled low only with reset high and latched error
      lnk.fault_status_n_oe <= lnk.reset_n & err_nxt;
      lnk.temp_warning_n_oe <= i_temp_warn;
    end
  end

  assign lnk.fault_status_n_o = 1'b0;  // open drain: only ever pulls low
  assign lnk.temp_warning_n_o = 1'b0;  // open drain: only ever pulls low
  assign o_err_latched        = err_r;
  assign o_ot_latched         = ot_r;
endmodule : psp_device
`default_nettype wire

// ### testbench/psp_assertions.sv
// concurrent checks on the link between the protection stage and its controller
`timescale 1ns/10ps
`default_nettype none
module psp_assertions (
  input wire logic I_CLK,               // system clock
  input wire logic I_RST,               // sync reset, active high
  input wire logic reset_n,             // stage reset, active low
  input wire logic protect_mode_sel_hi, // protection strap
  input wire logic protect_mode_sel_lo, // protection strap
  input wire logic output_mode_sel,     // output strap
  input wire logic pwm_active,          // modulator running
  input wire logic fault_status_n_o,    // fault pin drive value
  input wire logic fault_status_n_oe,   // fault pin pulled low
  input wire logic temp_warning_n_o,    // warning pin drive value
  input wire logic temp_warning_n_oe,   // warning pin pulled low
  input wire logic fault_status_n,      // resolved fault pin
  input wire logic temp_warning_n       // resolved warning pin
);
  // ******************************************************
  // helper: how long pwm has run, saturating so it never wraps
  // ******************************************************
  default clocking dc @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);
  logic [15:0] pwm_cnt_r;    // cycles of pwm so far
  logic [15:0] pwm_cnt_nxt;  // next count
  always_comb begin
    pwm_cnt_nxt = pwm_cnt_r;
    if (!pwm_active) pwm_cnt_nxt = 16'h0;
    else if (pwm_cnt_r != 16'hffff) pwm_cnt_nxt = pwm_cnt_r + 16'h1;
  end
  always_ff @(posedge I_CLK) begin
    pwm_cnt_r <= I_RST ? 16'h0 : pwm_cnt_nxt;
  end
  // ******************************************************
  // properties
  // ******************************************************
  property p_straps; {protect_mode_sel_hi, protect_mode_sel_lo} == psp_pkg::MODE_LATCHED; endproperty
  a_straps: assert property (p_straps)
    else $error("protection straps not latched mode");
  property p_out_strap; output_mode_sel == psp_pkg::OUT_MODE_BTL; endproperty
  a_out_strap: assert property (p_out_strap)
    else $error("output strap not bridge tied load");
  property p_fault_forced; !reset_n |=> !fault_status_n_oe; endproperty
  a_fault_forced: assert property (p_fault_forced)
    else $error("fault pin pulled low while reset low");
  property p_fault_needs_run; $rose(fault_status_n_oe) |-> $past(reset_n); endproperty
  a_fault_needs_run: assert property (p_fault_needs_run)
    else $error("fault pin fell without reset high");
  property p_od_levels;
    fault_status_n == !fault_status_n_oe && temp_warning_n == !temp_warning_n_oe;
  endproperty
  a_od_levels: assert property (p_od_levels)
    else $error("open drain pin level wrong");
  property p_od_drive; !fault_status_n_o && !temp_warning_n_o; endproperty
  a_od_drive: assert property (p_od_drive)
    else $error("open drain pin drives a high level");
  property p_fault_drops_rst; reset_n && !fault_status_n |-> ##[1:3] !reset_n; endproperty
  a_fault_drops_rst: assert property (p_fault_drops_rst)
    else $error("reset kept high during fault");
  property p_rise_clean; $rose(reset_n) |-> fault_status_n && $past(fault_status_n); endproperty
  a_rise_clean: assert property (p_rise_clean)
    else $error("reset raised with fault shown");
  property p_pwm_first; $rose(reset_n) |-> pwm_cnt_r >= psp_pkg::PWM_STABLE_CYC - 2; endproperty
  a_pwm_first: assert property (p_pwm_first)
    else $error("reset raised before pwm was stable");
  property p_rst_before_stop; $fell(pwm_active) |-> !reset_n; endproperty
  a_rst_before_stop: assert property (p_rst_before_stop)
    else $error("pwm stopped with reset high");
endmodule : psp_assertions
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench for the protection stage and its controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ******************************************************
  // stimulus and observed signals
  // ******************************************************
  logic        clk, rst;                     // clock, sync reset
  logic        psel, penable, pwrite, er;    // apb request, last error
  logic [7:0]  paddr;                        // apb address
  logic [31:0] pwdata, prdata, rd;           // apb data, last read
  logic        pready, pslverr, pwm_en, irq; // controller outputs
  logic        hiz, err_l, ot_l;             // stage status
  logic [1:0]  oc_hi, oc_lo, pair;           // overcurrent inputs, pin pair
  logic        t_warn, t_shut, sup_ok;       // sensor inputs
  logic        pwm_a, pwm_b;                 // complementary pwm
  logic [3:0]  gates;                        // a_hi a_lo b_hi b_lo
  int          bad_count, samples_checked, cyc; // counters
  psp_if lnk();
  assign pair = {lnk.temp_warning_n, lnk.fault_status_n};
  psp_device i_psp_device (.I_CLK(clk), .I_RST(rst), .lnk(lnk.dev), .i_oc_hi(oc_hi),
    .i_oc_lo(oc_lo), .i_temp_warn(t_warn), .i_temp_shut(t_shut), .i_gate_supply_ok(sup_ok),
    .i_pwm_a(pwm_a), .i_pwm_b(pwm_b), .o_out_a_hi(gates[3]), .o_out_a_lo(gates[2]),
    .o_out_b_hi(gates[1]), .o_out_b_lo(gates[0]), .o_hiz(hiz), .o_err_latched(err_l),
    .o_ot_latched(ot_l));
  psp_controller i_psp_controller (.I_CLK(clk), .I_RST(rst), .lnk(lnk.ctl), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .o_pwm_en(pwm_en), .o_irq(irq));
  psp_assertions i_psp_assertions (.I_CLK(clk), .I_RST(rst), .reset_n(lnk.reset_n),
    .protect_mode_sel_hi(lnk.protect_mode_sel_hi), .protect_mode_sel_lo(lnk.protect_mode_sel_lo),
    .output_mode_sel(lnk.output_mode_sel), .pwm_active(lnk.pwm_active),
    .fault_status_n_o(lnk.fault_status_n_o), .fault_status_n_oe(lnk.fault_status_n_oe),
    .temp_warning_n_o(lnk.temp_warning_n_o), .temp_warning_n_oe(lnk.temp_warning_n_oe),
    .fault_status_n(lnk.fault_status_n), .temp_warning_n(lnk.temp_warning_n));
  // ******************************************************
  // clock, pwm stream and hang guard
  // ******************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    pwm_a <= ~pwm_a;  // keeps switching, never a constant high
    pwm_b <= pwm_a;   // inverse of a after this edge
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  // ******************************************************
  // shared tasks
  // ******************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer; read data and error taken at the access edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    er = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);  // let the access edge settle before callers look
  endtask : apb
  task automatic start_run();
    apb(1'b1, psp_pkg::REG_CTRL, 32'h3);
    while (lnk.reset_n !== 1'b1) @(posedge clk);
    repeat (3) @(negedge clk);
    chk(hiz, 1'b0);
    chk(pair, psp_pkg::STAT_NORMAL);
    chk(gates, {~pwm_a, pwm_a, ~pwm_b, pwm_b});
    apb(1'b0, psp_pkg::REG_IRQ_STAT, 32'h0);
    chk(rd[psp_pkg::IRQ_RUN], 1'b1);
    chk(irq, 1'b1);
    apb(1'b1, psp_pkg::REG_IRQ_STAT, 32'hf);
    chk(irq, 1'b0);
  endtask : start_run
  // ******************************************************
  // scenarios
  // ******************************************************
  task automatic t_regs();
    @(negedge clk);
    chk(hiz, 1'b1);
    chk(lnk.fault_status_n, 1'b1);
    apb(1'b0, psp_pkg::REG_CTRL, 32'h0);
    chk(rd, psp_pkg::CTRL_RST_VAL);
    apb(1'b0, psp_pkg::REG_IRQ_MASK, 32'h0);
    chk(rd[3:0], psp_pkg::MASK_RST_VAL);
    apb(1'b1, 8'h10, 32'hf);  // unmapped place
    chk(er, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, psp_pkg::REG_IRQ_MASK, 32'hf);
    apb(1'b0, psp_pkg::REG_IRQ_MASK, 32'h0);
    chk(rd[3:0], 4'hf);
    $display("test regs done");
  endtask : t_regs
  // warning only: stage keeps running, interrupt masked then unmasked
  task automatic t_warn_irq();
    apb(1'b1, psp_pkg::REG_IRQ_MASK, 32'h0);
    @(posedge clk);
    t_warn <= 1'b1;
    repeat (3) @(negedge clk);
    chk(pair, psp_pkg::STAT_OT_WARN);
    chk(hiz, 1'b0);
    chk(irq, 1'b0);
    apb(1'b0, psp_pkg::REG_IRQ_STAT, 32'h0);
    chk(rd[psp_pkg::IRQ_WARN], 1'b1);
    apb(1'b1, psp_pkg::REG_IRQ_MASK, 32'h2);
    chk(irq, 1'b1);
    @(posedge clk);
    t_warn <= 1'b0;
    repeat (3) @(negedge clk);
    chk(pair, psp_pkg::STAT_NORMAL);
    apb(1'b1, psp_pkg::REG_IRQ_STAT, 32'h2);
    chk(irq, 1'b0);
    apb(1'b1, psp_pkg::REG_IRQ_MASK, 32'hf);
    $display("test warning done");
  endtask : t_warn_irq
  // every error source in turn, each followed by recovery
  task automatic t_errors();
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      if (k < 2) oc_hi[k] <= 1'b1;
      else if (k < 4) oc_lo[k-2] <= 1'b1;
      else if (k == 4) sup_ok <= 1'b0;
      else t_shut <= 1'b1;
      if (k == 5) t_warn <= 1'b1;  // warning comes with shutdown heat
      repeat (2) @(negedge clk);
      chk(err_l, 1'b1);
      chk({hiz, gates}, 5'h10);
      chk(ot_l, k == 5);
      chk(pair, (k == 5) ? psp_pkg::STAT_OT_ERR : psp_pkg::STAT_OC_UV_ERR);
      @(posedge clk);
      oc_hi <= 2'h0;
      oc_lo <= 2'h0;
      sup_ok <= 1'b1;
      t_shut <= 1'b0;
      t_warn <= 1'b0;
      repeat (20) @(negedge clk);
      chk(hiz, 1'b1);
      chk(err_l, 1'b0);
      chk(lnk.fault_status_n, 1'b1);
      apb(1'b0, psp_pkg::REG_IRQ_STAT, 32'h0);
      chk(rd[3:0], (k == 5) ? 4'h7 : 4'h1);
      apb(1'b0, psp_pkg::REG_CTRL, 32'h0);
      chk(rd[0], 1'b0);
      apb(1'b1, psp_pkg::REG_IRQ_STAT, 32'hf);
      start_run();
    end
    $display("test errors done");
  endtask : t_errors
  task automatic t_stop();
    apb(1'b1, psp_pkg::REG_CTRL, 32'h0);
    repeat (5) @(negedge clk);
    chk({lnk.reset_n, hiz, gates}, 6'h10);
    chk(pwm_en, 1'b0);
    $display("test stop done");
  endtask : t_stop
  task automatic complete_run();
    $display("counts: %0d mismatches in %0d checks", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {3'h4, 41'h0};
    {oc_hi, oc_lo, t_warn, t_shut, sup_ok, pwm_a, pwm_b} = 9'h05;
    {bad_count, samples_checked, cyc} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    start_run();
    t_warn_irq();
    t_errors();
    t_stop();
    complete_run();
  end
endmodule : tb
`default_nettype wire
